//--- pkg/utc_pkg.sv
package utc_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int          COUNT_W      = 16;       // counter width
    localparam int          DIV_SEL_W    = 3;        // divider select width
    localparam int          PRESC_W      = 15;       // covers 2^7 * 2^8
    localparam logic [3:0]  EXTRA_SHIFT  = 4'h8;     // divide by 256

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;    // mode and divider
    localparam logic [7:0]  ADDR_STROBE  = 8'h04;    // write-only strobes
    localparam logic [7:0]  ADDR_PERIOD  = 8'h08;    // period_value_reg
    localparam logic [7:0]  ADDR_COUNT   = 8'h0c;    // counter value
    localparam logic [7:0]  ADDR_STATUS  = 8'h10;    // read-only state

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int          CTRL_DIV_LSB    = 0;     // clock_divider_select
    localparam int          CTRL_EXTRA_BIT  = 3;     // extra_divider_enable
    localparam int          CTRL_STOP_BIT   = 4;     // one_period_stop
    localparam int          CTRL_MODE_LSB   = 5;     // count_input_select
    localparam int          CTRL_TEC_LSB    = 7;     // trigger_event_select
    localparam int          CTRL_TED_LSB    = 10;    // trigger_direction_select
    localparam int          CTRL_USED_W     = 12;    // bits kept
    localparam logic [11:0] CTRL_RESET      = 12'h000;

    // ------------------------------------------------------------
    // strobe and status fields
    // ------------------------------------------------------------
    localparam int          STB_RUN_SET  = 0;        // set run_flag
    localparam int          STB_RUN_CLR  = 1;        // clear run_flag
    localparam int          STB_CNT_CLR  = 2;        // counter_clear_strobe
    localparam int          STB_SOFT     = 3;        // soft_count_strobe
    localparam int          ST_RUN       = 0;        // run flag
    localparam int          ST_PM        = 1;        // period match
    localparam int          ST_ZM        = 2;        // zero match
    localparam logic [15:0] PERIOD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET  = 16'h0000;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UTC_MODE_TIMER = 2'b00,
        UTC_MODE_SOFT  = 2'b01,
        UTC_MODE_RISE  = 2'b10,
        UTC_MODE_FALL  = 2'b11
    } utc_mode_t;

    typedef enum logic [2:0] {
        UTC_TEC_NONE = 3'b000,
        UTC_TEC_CM0  = 3'b001,
        UTC_TEC_CM1  = 3'b010,
        UTC_TEC_CM2  = 3'b011,
        UTC_TEC_CMX  = 3'b100,
        UTC_TEC_PM   = 3'b101,
        UTC_TEC_ZMUP = 3'b110,
        UTC_TEC_HALL = 3'b111
    } utc_tec_t;

    typedef enum logic [1:0] {
        UTC_TED_NONE = 2'b00,
        UTC_TED_UP   = 2'b01,
        UTC_TED_DOWN = 2'b10,
        UTC_TED_ANY  = 2'b11
    } utc_ted_t;

endpackage

//--- pkg/utc_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// link between control logic and prescaler
interface utc_tick_if;
    logic       clear;      // hold prescaler in reset
    logic [2:0] div_sel;    // power of two select
    logic       extra_en;   // extra divide by 256
    logic       tick;       // one-cycle timer clock enable
    modport ctrl  (output clear, output div_sel, output extra_en, input tick);
    modport presc (input clear, input div_sel, input extra_en, output tick);
endinterface // utc_tick_if
`default_nettype wire

//--- verilog/utc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module utc_prescaler
    import utc_pkg::*;
(
    // clock and reset
    input  wire logic   hclk,
    input  wire logic   hresetn,
    // control side
    utc_tick_if.presc   tif
);

    // ------------------------------------------------------------
    // free divider chain
    // ------------------------------------------------------------
    logic [PRESC_W-1:0] cnt;        // running divider count
    logic [3:0]         shift;      // log2 of ratio
    logic [15:0]        one_hot;    // ratio as a single bit
    logic [PRESC_W-1:0] mask;       // ratio minus one

    // ratio is 2^(n) or 2^(n+8), so a tick is all masked bits high
    always_comb
    begin
        shift   = {1'b0, tif.div_sel} + (tif.extra_en ? EXTRA_SHIFT : 4'h0);
        one_hot = 16'h0001 << shift;
        mask    = one_hot[PRESC_W-1:0] - 15'h0001;  // wraps to all ones at 2^15
    end

    // counter is held at zero while stopped for a known phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt <= '0;
        else if (tif.clear)
            cnt <= '0;
        else
            cnt <= cnt + 15'h0001;
    end

    // code 000 without extra gives a tick every cycle
    assign tif.tick = !tif.clear && ((cnt & mask) == mask);

endmodule // utc_prescaler
`default_nettype wire

//--- verilog/utc_top.sv
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module utc_top
    import utc_pkg::*;
#(
    parameter int CNT_W = COUNT_W                    // counter width
)
(
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    // reference timer events, same clock, one-cycle pulses; the count direction is a level
    input  wire logic              reference_compare_match_ch0,
    input  wire logic              reference_compare_match_ch1,
    input  wire logic              reference_compare_match_ch2,
    input  wire logic              reference_period_match,
    input  wire logic              reference_zero_match,
    input  wire logic              reference_count_direction,
    input  wire logic              hall_state_change,
    // external pin
    input  wire logic              external_count_input,
    // timer state towards compare logic
    output logic                   run_flag,
    output logic                   period_match,
    output logic                   zero_match,
    output logic                   timer_tick,
    output logic [CNT_W-1:0]       count_value
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (CNT_W < 2 || CNT_W > 16)
    begin : g_bad_width
        $error("utc_top: CNT_W must lie between 2 and 16");
    end

    // selected reference event, qualified by direction
    function automatic logic utc_event_hit(
        input logic [2:0] tec, input logic [1:0] ted,
        input logic cm0, input logic cm1, input logic cm2,
        input logic pm, input logic zm, input logic dir, input logic hall
    );
        logic ev;
        logic dir_ok;
        ev     = 1'b0;
        dir_ok = 1'b0;
        unique case (utc_tec_t'(tec))
            UTC_TEC_NONE: ev = 1'b0;
            UTC_TEC_CM0:  ev = cm0;
            UTC_TEC_CM1:  ev = cm1;
            UTC_TEC_CM2:  ev = cm2;
            UTC_TEC_CMX:  ev = cm0 | cm1 | cm2;
            UTC_TEC_PM:   ev = pm;
            UTC_TEC_ZMUP: ev = zm & ~dir;
            UTC_TEC_HALL: ev = hall;
        endcase
        unique case (utc_ted_t'(ted))
            UTC_TED_NONE: dir_ok = 1'b0;
            UTC_TED_UP:   dir_ok = ~dir;
            UTC_TED_DOWN: dir_ok = dir;
            UTC_TED_ANY:  dir_ok = 1'b1;
        endcase
        return ev & dir_ok;
    endfunction

    // register word to byte offset match
    function automatic logic utc_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ------------------------------------------------------------
    // bus slave state
    // ------------------------------------------------------------
    logic [7:0]          dph_addr;      // latched address of data phase
    logic                dph_write;     // data phase is a write
    logic                addr_valid;    // address phase accepted
    logic [11:0]         ctrl;          // control register bits
    logic [15:0]         period_value_reg; // period compare value
    logic [CNT_W-1:0]    count;         // counter
    logic [31:0]         next_rdata;    // read mux

    assign addr_valid = hsel && hready && htrans[1];

    // address phase capture; the slave never inserts waits
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dph_addr  <= 8'h00;
            dph_write <= 1'b0;
        end
        else if (hready)
        begin
            dph_addr  <= haddr[7:0];
            dph_write <= addr_valid && hwrite && (haddr[31:8] == 24'h000000);
        end
    end

    // constant answers still come from flops so outputs are clean
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;               // zero wait states
            hresp     <= 1'b0;               // always okay
        end
    end

    // ------------------------------------------------------------
    // decoded write strobes (data phase)
    // ------------------------------------------------------------
    wire logic wr_ctrl   = dph_write && utc_hit(dph_addr, ADDR_CTRL);   // control write
    wire logic wr_strobe = dph_write && utc_hit(dph_addr, ADDR_STROBE); // strobe write
    wire logic wr_period = dph_write && utc_hit(dph_addr, ADDR_PERIOD); // period write
    wire logic wr_count  = dph_write && utc_hit(dph_addr, ADDR_COUNT);  // counter write
    wire logic sw_set    = wr_strobe && hwdata[STB_RUN_SET];            // software run set
    wire logic sw_clr    = wr_strobe && hwdata[STB_RUN_CLR];            // software run clear
    wire logic cnt_clr   = wr_strobe && hwdata[STB_CNT_CLR];            // counter clear strobe
    wire logic soft_step = wr_strobe && hwdata[STB_SOFT];               // soft count strobe

    // control fields; changing them while running is allowed
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl <= CTRL_RESET;
        else if (wr_ctrl)
            ctrl <= hwdata[CTRL_USED_W-1:0];
    end

    // period value; a zero period while running is software's fault
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            period_value_reg <= PERIOD_RESET;
        else if (wr_period)
            period_value_reg <= hwdata[15:0];
    end

    // field views of the control register
    wire logic [2:0] clock_divider_select     = ctrl[CTRL_DIV_LSB +: 3];
    wire logic       extra_divider_enable     = ctrl[CTRL_EXTRA_BIT];
    wire logic       one_period_stop          = ctrl[CTRL_STOP_BIT];
    wire logic [1:0] count_input_select       = ctrl[CTRL_MODE_LSB +: 2];
    wire logic [2:0] trigger_event_select     = ctrl[CTRL_TEC_LSB +: 3];
    wire logic [1:0] trigger_direction_select = ctrl[CTRL_TED_LSB +: 2];

    // ------------------------------------------------------------
    // external input synchroniser and edge detect
    // ------------------------------------------------------------
    logic ext_meta;                  // first stage, read only by ext_sync
    logic ext_sync;                  // second stage
    logic ext_prev;                  // delayed copy for edge detect

    // two flops before any logic looks at the pin
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end
        else
        begin
            ext_meta <= external_count_input;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // pulses shorter than one cycle may be missed
    wire logic ext_rise = ext_sync & ~ext_prev;  // one cycle per rising edge
    wire logic ext_fall = ~ext_sync & ext_prev;  // one cycle per falling edge

    // prescaler link
    utc_tick_if tick_bus ();

    assign tick_bus.clear    = !run_flag;
    assign tick_bus.div_sel  = clock_divider_select;
    assign tick_bus.extra_en = extra_divider_enable;

    utc_prescaler u_presc (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tif     (tick_bus)
    );

    // ------------------------------------------------------------
    // step selection and next state
    // ------------------------------------------------------------
    logic             step;          // one counting step this cycle
    logic             at_period;     // counter equals period value
    logic             trig;          // qualified start event
    logic             stop_hw;       // single-shot end of period
    logic             next_run;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] period_cmp;    // period sized to the counter
    logic [CNT_W-1:0] next_period_cmp;

    assign period_cmp      = period_value_reg[CNT_W-1:0];
    assign next_period_cmp = wr_period ? hwdata[CNT_W-1:0] : period_cmp;
    assign at_period       = (count == period_cmp);

    // steps are only taken while running, in every mode
    always_comb
    begin
        step = 1'b0;
        unique case (utc_mode_t'(count_input_select))
            UTC_MODE_TIMER: step = tick_bus.tick;
            UTC_MODE_SOFT:  step = soft_step;
            UTC_MODE_RISE:  step = ext_rise;
            UTC_MODE_FALL:  step = ext_fall;
        endcase
        step = step && run_flag;
    end

    // events are hclk pulses, so any prescaler ratio sees them
    assign trig = utc_event_hit(trigger_event_select, trigger_direction_select,
                                reference_compare_match_ch0,
                                reference_compare_match_ch1,
                                reference_compare_match_ch2,
                                reference_period_match,
                                reference_zero_match,
                                reference_count_direction,
                                hall_state_change);

    assign stop_hw = step && at_period && one_period_stop;

    // setting wins over clearing; set and clear together hold
    always_comb
    begin
        next_run = run_flag;
        if (trig || (sw_set && !sw_clr))
            next_run = 1'b1;
        else if ((sw_clr && !sw_set) || stop_hw)
            next_run = 1'b0;
    end

    // counter: clear strobe first, then stopped write, then step
    always_comb
    begin
        next_count = count;
        if (cnt_clr)
            next_count = '0;
        else if (wr_count && !run_flag)
            next_count = hwdata[CNT_W-1:0];
        else if (step && at_period)
            next_count = '0;
        else if (step)
            next_count = count + 1'b1;
    end

    // run flag and counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            run_flag <= 1'b0;
            count    <= COUNT_RESET[CNT_W-1:0];
        end
        else
        begin
            run_flag <= next_run;
            count    <= next_count;
        end
    end

    // match flags track the counter as it will be next cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            period_match <= 1'b0;
            zero_match   <= 1'b1;
            timer_tick   <= 1'b0;
            count_value  <= COUNT_RESET[CNT_W-1:0];
        end
        else
        begin
            period_match <= (next_count == next_period_cmp);
            zero_match   <= (next_count == '0);
            timer_tick   <= step;
            count_value  <= next_count;
        end
    end

    // read mux: strobe register and unmapped offsets read zero
    always_comb
    begin
        next_rdata = 32'h00000000;
        if (haddr[31:8] == 24'h000000)
        begin
            unique case (haddr[7:0])
                ADDR_CTRL:   next_rdata[CTRL_USED_W-1:0] = ctrl;
                ADDR_PERIOD: next_rdata[15:0] = period_value_reg;
                ADDR_COUNT:  next_rdata[CNT_W-1:0] = count;
                ADDR_STATUS:
                begin
                    next_rdata[ST_RUN] = run_flag;
                    next_rdata[ST_PM]  = at_period;
                    next_rdata[ST_ZM]  = (count == '0);
                end
                default:     next_rdata = 32'h00000000;
            endcase
        end
    end

    // sampled at the address phase, shown in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (addr_valid && !hwrite)
            hrdata <= next_rdata;
    end

endmodule // utc_top
`default_nettype wire

//--- tb/utc_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// counting core checks
// ----------------------------------------
module utc_properties
    import utc_pkg::*;
#(
    parameter int CNT_W = COUNT_W
)
(
    // bus
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic             hsel,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic             hready,
    input wire logic             hreadyout,
    input wire logic             hresp,
    input wire logic [31:0]      hrdata,
    // timer state
    input wire logic             run_flag,
    input wire logic             period_match,
    input wire logic             zero_match,
    input wire logic [CNT_W-1:0] count_value
);
    logic req;   // request taken at this edge
    logic wr_d;  // write data phase: registers change at its edge
    assign req = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) wr_d <= 1'b0;
        else wr_d <= req && hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // a count change made while running, so by a step or a clear strobe, never by a count write
    sequence s_run_chg;
        $past(run_flag) && $changed(count_value);
    endsequence
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    chk_rdata_hold: assert property ($changed(hrdata) |-> $past(req && !hwrite))
        else $error("read data moved without a read");
    chk_stopped_hold: assert property (
        $changed(count_value) && !$past(run_flag) |-> $past(wr_d))
        else $error("stopped counter moved");
    chk_count_up: assert property (
        s_run_chg |-> count_value == $past(count_value) + 1'b1 || count_value == 0)
        else $error("counter did not step up by one");
    chk_period_wrap: assert property (
        s_run_chg ##0 $past(period_match) |-> count_value == 0)
        else $error("counter did not wrap at period");
    chk_zero_flag: assert property (zero_match == (count_value == 0))
        else $error("zero flag out of step");
    chk_run_stop: assert property (
        $fell(run_flag) |-> $past(wr_d) || $past(period_match))
        else $error("run dropped before period end");
    chk_shot_zero: assert property (
        $fell(run_flag) && !$past(wr_d) |-> count_value == 0)
        else $error("single shot stopped off zero");
endmodule // utc_properties
`default_nettype wire

//--- tb/utc_ref_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// reference timer event source
// ----------------------------------------
module utc_ref_model
(
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // bench requests
    input  wire logic       fire,  // pulse the selected line once
    input  wire logic [2:0] sel,   // 0-2 compare, 3 period, 4 zero, 5 hall
    input  wire logic       down,  // wanted count direction
    // towards the timer
    output logic [5:0]      ev,    // one-cycle event pulses
    output logic            dir    // high while counting down
);
    // matches last one clock, as the real timer's do
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) ev <= 6'h00;
        else ev <= fire ? 6'h01 << sel : 6'h00;
    // direction is a level, moved only between events
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) dir <= 1'b0;
        else dir <= down;
endmodule // utc_ref_model
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb;
    import utc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, run_flag, fire, down, pin, dir;
    logic        dn, e, tt;  // trigger direction, expected start; timer tick
    logic [1:0]  htrans, d;  // d: direction qualifier code
    logic [2:0]  sel, t;     // t: event code
    logic [5:0]  ev;
    logic [15:0] count_value;
    logic [31:0] haddr, hwdata, hrdata, q;
    int          n_errors = 0, total_checks = 0, k;
    utc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .reference_compare_match_ch0(ev[0]), .reference_compare_match_ch1(ev[1]),
        .reference_compare_match_ch2(ev[2]), .reference_period_match(ev[3]),
        .reference_zero_match(ev[4]), .hall_state_change(ev[5]),
        .reference_count_direction(dir), .external_count_input(pin), .run_flag(run_flag),
        .period_match(), .zero_match(), .timer_tick(tt), .count_value(count_value));
    utc_ref_model ref_u (.hclk(hclk), .hresetn(hresetn), .fire(fire), .sel(sel),
        .down(down), .ev(ev), .dir(dir));
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // ----------------------------------------
    // bus and wait helpers
    // ----------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic bail;
        n_errors++;
        end_sim;
    endtask
    // edge with hready high; the bound cuts a hung slave short
    task automatic wait_rdy;
        int i;
        i = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            if (++i > 64) bail;
            @(posedge hclk);
        end
    endtask
    // one single word transfer; q holds read data
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= dat;
        wait_rdy;
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        `CHK(q, x)
    endtask
    // negedges until run flag and count reach v
    task automatic gap(input logic [16:0] v);
        k = -1;
        do
        begin
            @(negedge hclk);
            if (++k > 40000) bail;
        end
        while ({run_flag, count_value} !== v);
    endtask
    task automatic pulse;
        repeat (2)
        begin
            pin <= 1'b1;
            repeat (4) @(posedge hclk);
            pin <= 1'b0;
            repeat (4) @(posedge hclk);
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {hresetn, hsel, hwrite, fire, down, pin, htrans, sel, haddr, hwdata} = '0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_STATUS, 32'h6);
        rd(ADDR_STROBE, 32'h0);
        rd(8'h40, 32'h0);
        $display("test reset done");
        // every start begins from a cleared prescaler
        for (int i = 0; i < 10; i++)
        begin
            bus(1'b1, ADDR_STROBE, 32'h2);
            bus(1'b1, ADDR_CTRL, i < 8 ? i : (i == 8 ? 32'h8 : 32'hf));
            bus(1'b1, ADDR_PERIOD, 32'h3);
            bus(1'b1, ADDR_STROBE, 32'h5);
            gap({1'b1, 16'h1});
            `CHK(k, i < 8 ? 1 << i : (i == 8 ? 256 : 32768))
            `CHK(tt, 1'b1)
        end
        $display("test prescaler done");
        bus(1'b1, ADDR_STROBE, 32'h2);
        bus(1'b1, ADDR_CTRL, 32'h10);
        bus(1'b1, ADDR_PERIOD, 32'h2);
        bus(1'b1, ADDR_STROBE, 32'h5);
        gap({1'b0, 16'h0});
        `CHK(k, 3)
        rd(ADDR_STATUS, 32'h4);
        $display("test single shot done");
        bus(1'b1, ADDR_CTRL, 32'h20);
        bus(1'b1, ADDR_PERIOD, 32'hffff);
        bus(1'b1, ADDR_STROBE, 32'h8);
        bus(1'b1, ADDR_COUNT, 32'h7);
        rd(ADDR_COUNT, 32'h7);
        bus(1'b1, ADDR_STROBE, 32'h1);
        repeat (3) bus(1'b1, ADDR_STROBE, 32'h8);
        bus(1'b1, ADDR_COUNT, 32'h0);
        rd(ADDR_COUNT, 32'ha);
        bus(1'b1, ADDR_STROBE, 32'h4);
        rd(ADDR_STATUS, 32'h5);
        bus(1'b1, ADDR_CTRL, 32'h40);
        pulse;
        rd(ADDR_COUNT, 32'h2);
        bus(1'b1, ADDR_CTRL, 32'h60);
        pulse;
        rd(ADDR_COUNT, 32'h4);
        $display("test count modes done");
        bus(1'b1, ADDR_PERIOD, 32'h100);
        for (int j = 0; j < 16; j++)
        begin
            t = j < 8 ? j[2:0] : 3'h5;
            d = j < 8 ? 2'h3 : j[1:0];
            dn = j >= 8 && j[2];
            e = t != 3'h0 && d != 2'h0 && (d == 2'h3 || d[1] == dn);
            bus(1'b1, ADDR_STROBE, 32'h6);
            bus(1'b1, ADDR_CTRL, {20'h0, d, t, 7'h07});
            down <= dn;
            sel <= t == 3'h0 ? 3'h0 : t < 3'h4 ? t - 3'h1 : t == 3'h4 ? 3'h2 : t - 3'h2;
            @(posedge hclk);
            fire <= 1'b1;
            @(posedge hclk);
            fire <= 1'b0;
            bus(1'b0, ADDR_STATUS, 32'h0);
            `CHK(q[0], e)
        end
        $display("test triggers done");
        end_sim;
    end
endmodule // tb
bind utc_top utc_properties #(.CNT_W(CNT_W)) chk_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .run_flag(run_flag), .period_match(period_match),
    .zero_match(zero_match), .count_value(count_value));
`default_nettype wire
